/* design/cfg_pins_pkg.sv */
// shared types and constants for the configuration clock and data pins
// assumes one 20 MHz clock; pin levels are resolved outside the design
package cfg_pins_pkg;

    // ------------------------------------------------------------------
    // schemes, states and carriers
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SCHEME_PASSIVE_SERIAL        = 2'h0,
        SCHEME_FAST_PASSIVE_PARALLEL = 2'h1,
        SCHEME_ACTIVE_SERIAL         = 2'h2,
        SCHEME_ACTIVE_PARALLEL       = 2'h3
    } scheme_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_CMD  = 4'h2,
        ST_LOAD = 4'h4,
        ST_DONE = 4'h8
    } load_state_t;

    // one captured unit: a byte in the low half, or a 16-bit word
    typedef struct packed {
        logic [15:0] data;
        logic        wide;
    } cfg_word_t;

    // level and enable of the three pins this block handles
    typedef struct packed {
        logic clk_o;
        logic clk_oe;
        logic d0_o;
        logic d0_oe;
        logic d1_o;
        logic d1_oe;
    } pin_drive_t;

    // ------------------------------------------------------------------
    // timing and framing constants
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 50;
    localparam int ACTIVE_HALF_NS   = 200;   // least half period, own clock
    localparam int ACTIVE_HALF_CYC  =
        (ACTIVE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CMD_BITS         = 32;
    localparam logic [31:0] READ_HEADER   = 32'h0300_0000;
    localparam int BYTE_BITS        = 8;
    localparam int BYTES_PER_WIDE   = 2;
    localparam int DEFAULT_BYTES    = 1024;
    localparam logic [2:0] BIT_LAST = 3'h7;

endpackage : cfg_pins_pkg

/* design/cfg_word_buffer.sv */
// small first-in first-out buffer for captured configuration words
// assumes producer and consumer share clk; rst is synchronous, active high
`timescale 1ns/100ps
module cfg_word_buffer #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    // ------------------------------------------------------------------
    // handshake and next pointers
    // ------------------------------------------------------------------
    assign in_ready  = (count != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointers wrap at depth so any depth works, not only powers of two
    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (push) begin
            next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    // register the pointers, write storage on push
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule : cfg_word_buffer

/* design/cfg_pin_loader.sv */
// configuration clock and low data pins of the loader, for all four schemes
// assumes pins arrive asynchronous to clk; scheme and user controls are
// static from logic on clk; tri-state wires are resolved outside
`timescale 1ns/100ps
module cfg_pin_loader
    import cfg_pins_pkg::*;
#(
    parameter int CONFIG_BYTES = cfg_pins_pkg::DEFAULT_BYTES
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire cfg_pins_pkg::scheme_t   scheme,
    input  wire logic                    ap_word_wide,
    input  wire logic                    user_pin_ctl,
    input  wire cfg_pins_pkg::pin_drive_t user_drive,
    input  wire logic                    clock_pin_in,
    input  wire logic [15:0]             data_pins_in,
    input  wire logic                    chip_enable_n,
    output cfg_pins_pkg::pin_drive_t     pins,
    output logic                         config_complete_flag_o,
    output logic                         config_complete_flag_oe,
    output logic [1:0]                   user_data_in,
    output logic                         word_valid,
    input  wire logic                    word_ready,
    output cfg_pins_pkg::cfg_word_t      word_data,
    output logic                         overflow,
    output logic                         config_done
);
    import cfg_pins_pkg::*;

    localparam int CW = $clog2(CONFIG_BYTES + BYTES_PER_WIDE + 1);
    localparam int HW = $clog2(ACTIVE_HALF_CYC + 1);

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic        clk_s1, clk_s2, clk_s3;
    logic [15:0] dat_s1, dat_s2;
    logic        ce_s1, ce_s2;

    // first stages feed only the second; edge logic uses s2 and s3
    always_ff @(posedge clk) begin
        clk_s1 <= clock_pin_in;
        clk_s2 <= clk_s1;
        clk_s3 <= clk_s2;
        dat_s1 <= data_pins_in;
        dat_s2 <= dat_s1;
        ce_s1  <= chip_enable_n;
        ce_s2  <= ce_s1;
    end

    // ------------------------------------------------------------------
    // loader state
    // ------------------------------------------------------------------
    load_state_t     state, next_state;
    logic [HW-1:0]   div, next_div;
    logic            gen_clk, next_gen_clk;
    logic [31:0]     cmd_sr, next_cmd_sr;
    logic [5:0]      cmd_cnt, next_cmd_cnt;
    logic [7:0]      byte_sr, next_byte_sr;
    logic [2:0]      bit_cnt, next_bit_cnt;
    logic [CW-1:0]   bytes_seen, next_bytes_seen;
    logic            next_overflow;
    pin_drive_t      next_pins;
    logic            passive, serial, active_mode, busy;
    logic            ext_rise, tick, rise_tick, fall_tick;
    logic            push, push_ready;
    cfg_word_t       push_word;

    assign passive     = (scheme == SCHEME_PASSIVE_SERIAL) ||
                         (scheme == SCHEME_FAST_PASSIVE_PARALLEL);
    assign active_mode = !passive;
    assign serial      = (scheme == SCHEME_PASSIVE_SERIAL) ||
                         (scheme == SCHEME_ACTIVE_SERIAL);
    assign busy        = (state == ST_CMD) || (state == ST_LOAD);
    assign ext_rise    = clk_s2 && !clk_s3;
    // the generated clock halts while the buffer is full: no word lost
    assign tick        = active_mode && busy && (div == '0) &&
                         (push_ready || state == ST_CMD);
    assign rise_tick   = tick && !gen_clk;
    assign fall_tick   = tick && gen_clk;

    // next values of the whole loader
    always_comb begin
        next_state      = state;
        next_div        = (div == '0) ? HW'(ACTIVE_HALF_CYC - 1)
                                      : div - 1'b1;
        next_gen_clk    = gen_clk;
        next_cmd_sr     = cmd_sr;
        next_cmd_cnt    = cmd_cnt;
        next_byte_sr    = byte_sr;
        next_bit_cnt    = bit_cnt;
        next_bytes_seen = bytes_seen;
        next_overflow   = overflow;
        push            = 1'b0;
        push_word       = '0;
        if (tick) begin
            next_gen_clk = !gen_clk;
        end
        case (state)
            ST_IDLE: begin
                next_gen_clk = 1'b0;
                next_cmd_sr  = READ_HEADER;
                next_cmd_cnt = '0;
                if (!ce_s2) begin
                    next_state = (scheme == SCHEME_ACTIVE_SERIAL)
                                 ? ST_CMD : ST_LOAD;
                end
            end
            ST_CMD: begin
                // shift on falling edges, flash samples on rising
                if (fall_tick) begin
                    next_cmd_sr  = {cmd_sr[30:0], 1'b0};
                    next_cmd_cnt = cmd_cnt + 1'b1;
                    if (cmd_cnt == 6'(CMD_BITS - 1)) begin
                        next_state = ST_LOAD;
                    end
                end
            end
            ST_LOAD: begin
                if ((passive && ext_rise) || rise_tick) begin
                    if (serial) begin
                        // least significant bit first on bit 0
                        next_byte_sr = {dat_s2[0], byte_sr[7:1]};
                        next_bit_cnt = bit_cnt + 1'b1;
                        if (bit_cnt == BIT_LAST) begin
                            push           = 1'b1;
                            push_word.data = {8'h00, dat_s2[0],
                                              byte_sr[7:1]};
                        end
                    end else begin
                        push = 1'b1;
                        if (scheme == SCHEME_ACTIVE_PARALLEL &&
                            ap_word_wide) begin
                            push_word.data = dat_s2;
                            push_word.wide = 1'b1;
                        end else begin
                            push_word.data = {8'h00, dat_s2[7:0]};
                        end
                    end
                end
                if (push) begin
                    next_bytes_seen = bytes_seen + (push_word.wide ?
                                      CW'(BYTES_PER_WIDE) : CW'(1));
                    // a passive host cannot be stalled; flag the loss
                    if (!push_ready) begin
                        next_overflow = 1'b1;
                    end
                end
                if (next_bytes_seen >= CW'(CONFIG_BYTES)) begin
                    next_state   = ST_DONE;
                    next_gen_clk = 1'b0;
                end
            end
            ST_DONE: begin
                next_state   = ST_DONE;
                next_gen_clk = 1'b0;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // next pin drive, taken from the next state so pins match state
    always_comb begin
        next_pins = '0;
        if (next_state == ST_DONE) begin
            // clock: passive never drives it; active idles low unless user_pin_ctl hands it to user_drive
            if (!passive) begin
                next_pins.clk_oe = 1'b1;
                if (user_pin_ctl) begin
                    next_pins.clk_o  = user_drive.clk_o;
                    next_pins.clk_oe = user_drive.clk_oe;
                end
            end
            // bit 0 stays an input after active serial
            if (scheme != SCHEME_ACTIVE_SERIAL && user_pin_ctl) begin
                next_pins.d0_o  = user_drive.d0_o;
                next_pins.d0_oe = user_drive.d0_oe;
            end
            if (scheme == SCHEME_ACTIVE_SERIAL) begin
                next_pins.d1_o  = user_pin_ctl ? user_drive.d1_o
                                               : 1'b1;
                next_pins.d1_oe = 1'b1;
            end else if (user_pin_ctl) begin
                next_pins.d1_o  = user_drive.d1_o;
                next_pins.d1_oe = user_drive.d1_oe;
            end
        end else if (active_mode && next_state != ST_IDLE) begin
            next_pins.clk_o  = next_gen_clk;
            next_pins.clk_oe = 1'b1;
            if (scheme == SCHEME_ACTIVE_SERIAL) begin
                // idle high once the header is out
                next_pins.d1_o  = (next_state == ST_CMD) ? next_cmd_sr[31]
                                                         : 1'b1;
                next_pins.d1_oe = 1'b1;
            end
        end
        // passive serial keeps bit 1 tri-stated while loading
    end

    // register loader state and pin drive
    always_ff @(posedge clk) begin
        if (rst) begin
            state      <= ST_IDLE;
            div        <= '0;
            gen_clk    <= 1'b0;
            cmd_sr     <= '0;
            cmd_cnt    <= '0;
            byte_sr    <= '0;
            bit_cnt    <= '0;
            bytes_seen <= '0;
            overflow   <= 1'b0;
            pins       <= '0;
        end else begin
            state      <= next_state;
            div        <= next_div;
            gen_clk    <= next_gen_clk;
            cmd_sr     <= next_cmd_sr;
            cmd_cnt    <= next_cmd_cnt;
            byte_sr    <= next_byte_sr;
            bit_cnt    <= next_bit_cnt;
            bytes_seen <= next_bytes_seen;
            overflow   <= next_overflow;
            pins       <= next_pins;
        end
    end

    // ------------------------------------------------------------------
    // outputs and buffer
    // ------------------------------------------------------------------
    // open drain: only ever pulls low, released once loading is done
    assign config_complete_flag_o  = 1'b0;
    assign config_complete_flag_oe = (state != ST_DONE);
    assign config_done             = (state == ST_DONE);
    assign user_data_in            = dat_s2[1:0];

    cfg_word_buffer #(
        .WIDTH ($bits(cfg_word_t)),
        .DEPTH (2)
    ) u_buffer (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (push_ready),
        .in_data   (push_word),
        .out_valid (word_valid),
        .out_ready (word_ready),
        .out_data  (word_data)
    );

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_passive_clk_hiz: assert property (passive |-> !pins.clk_oe)
        else $error("passive scheme drives the clock pin");
    a_active_clk_drv: assert property (active_mode && busy |->
        pins.clk_oe && pins.clk_o == gen_clk)
        else $error("active scheme does not drive the clock");
    a_active_clk_idle: assert property (active_mode && config_done &&
        !user_pin_ctl |-> pins.clk_oe && !pins.clk_o)
        else $error("clock not inactive after completion");
    a_done_frozen: assert property (config_done |=> config_done &&
        $stable(bytes_seen))
        else $error("state changed after completion");
    a_flag_release: assert property ((config_complete_flag_oe !=
        config_done) && (config_done == (bytes_seen >= CW'(CONFIG_BYTES))))
        else $error("completion flag out of step");
    a_cmd_fall_edge: assert property (scheme == SCHEME_ACTIVE_SERIAL &&
        state == ST_CMD && $changed(pins.d1_o) |-> $fell(pins.clk_o))
        else $error("command bit changed off falling edge");
    a_cmd_out_drv: assert property (scheme == SCHEME_ACTIVE_SERIAL &&
        (busy || config_done) && !user_pin_ctl |-> pins.d1_oe)
        else $error("command pin not driven");
    a_ps_d1_hiz: assert property (scheme == SCHEME_PASSIVE_SERIAL &&
        !config_done |-> !pins.d1_oe)
        else $error("bit 1 driven during passive serial load");
    a_as_d0_input: assert property (scheme == SCHEME_ACTIVE_SERIAL |->
        !pins.d0_oe)
        else $error("bit 0 driven in active serial");
    a_passive_sample: assert property (passive && push |-> clk_s2 &&
        !$past(clk_s2))
        else $error("passive capture off rising edge");
    // pins are registered, so they follow the user controls a cycle late
    a_user_pins: assert property (config_done && passive |=>
        pins.d1_oe == ($past(user_pin_ctl) && $past(user_drive.d1_oe)) &&
        pins.d0_oe == ($past(user_pin_ctl) && $past(user_drive.d0_oe)))
        else $error("user pin drive wrong after passive load");
    a_ap_user_pins: assert property (config_done &&
        scheme == SCHEME_ACTIVE_PARALLEL |=> pins.d0_oe ==
        ($past(user_pin_ctl) && $past(user_drive.d0_oe)))
        else $error("bit 0 control wrong after parallel load");
    a_serial_byte: assert property (serial && push |->
        bit_cnt == BIT_LAST && !push_word.wide)
        else $error("serial word not eight single bits");

    c_as_done: cover property (scheme == SCHEME_ACTIVE_SERIAL &&
        $rose(config_done));
    c_ap_wide: cover property (push && push_word.wide);
    c_stall: cover property (active_mode && busy && !push_ready);
    c_overflow: cover property ($rose(overflow));

endmodule : cfg_pin_loader

/* bench/cfg_partner_model.sv */
// far side of the loader: passive host and configuration flash
// assumes the bench calls host_send and fills mem before a load
`timescale 1ns/100ps
module cfg_partner_model
    import cfg_pins_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire cfg_pins_pkg::scheme_t   scheme,
    input  wire logic                    ap_word_wide,
    input  wire cfg_pins_pkg::pin_drive_t pins,
    output logic                         clock_pin_in,
    output logic [15:0]                  data_pins_in,
    output logic [31:0]                  header_seen,
    output int                           d1_slips
);
    // ------------------------------------------------------------------
    // host and flash
    // ------------------------------------------------------------------
    logic [7:0]  mem [8];
    logic        host_clk  = 1'b0;
    logic [15:0] host_data = 16'h0000;
    logic [15:0] flash_data;
    logic        prev_clk, prev_oe, prev_d1, rise, fall, active;
    int          rcount, idx;

    // undriven clock pin is pulled up in active schemes
    assign active       = scheme[1];
    assign clock_pin_in = active ? (pins.clk_oe ? pins.clk_o : 1'b1)
                                 : host_clk;
    assign data_pins_in = active ? flash_data : host_data;
    assign rise = pins.clk_oe && pins.clk_o && !prev_clk;
    assign fall = pins.clk_oe && !pins.clk_o && prev_clk;

    // one unit per clock, data changed while the clock is low
    task automatic host_send(input logic [7:0] b);
        int n;
        n = (scheme == SCHEME_PASSIVE_SERIAL) ? BYTE_BITS : 1;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            host_data <= (n == 1) ? {~b, b} : {15'h5555, b[i]};
            repeat (4) @(posedge clk);
            host_clk <= 1'b1;
            repeat (4) @(posedge clk);
            host_clk <= 1'b0;
        end
        @(posedge clk);
        host_data <= ~host_data; // stale value must not be trusted
    endtask : host_send

    // flash answers on the falling generated edge, device samples rising
    always @(posedge clk) begin
        prev_clk <= pins.clk_o;
        prev_oe  <= pins.clk_oe;
        prev_d1  <= pins.d1_o;
        if (rst) begin
            rcount      <= 0;
            idx         <= 0;
            header_seen <= 32'h0000_0000;
            d1_slips    <= 0;
            flash_data  <= 16'h0000;
        end else if (!active || !pins.clk_oe) begin
            // a parallel flash already shows its first unit; else no level
            if (scheme == SCHEME_ACTIVE_PARALLEL)
                flash_data <= ap_word_wide ? {mem[1], mem[0]}
                                           : {8'h00, mem[0]};
            else
                flash_data <= ~flash_data;
        end else if (scheme == SCHEME_ACTIVE_SERIAL) begin
            if (rise && rcount < CMD_BITS) begin
                header_seen <= {header_seen[30:0], pins.d1_o};
                rcount      <= rcount + 1;
            end
            if (rcount < CMD_BITS && prev_oe && pins.d1_o !== prev_d1
                && !fall)
                d1_slips <= d1_slips + 1;
            if (fall && rcount == CMD_BITS) begin
                flash_data <= {15'h0000, mem[(idx / 8) % 8][idx % 8]};
                idx        <= idx + 1;
            end
        end else if (!prev_oe || fall) begin
            flash_data <= ap_word_wide
                ? {mem[(2 * idx + 1) % 8], mem[(2 * idx) % 8]}
                : {8'h00, mem[idx % 8]};
            idx <= idx + 1;
        end
    end
endmodule : cfg_partner_model

/* bench/cfg_pin_loader_tb_top.sv */
// self-checking bench for the loader in all four schemes
// assumes the partner model sits on the pins; four bytes make a load
`timescale 1ns/100ps
module cfg_pin_loader_tb_top;
    import cfg_pins_pkg::*;
    // ------------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------------
    localparam int N_BYTES = 4;
    logic         clk, rst, ap_word_wide, user_pin_ctl, chip_enable_n;
    logic         clock_pin_in, flag_o, flag_oe, word_valid, word_ready;
    logic         overflow, config_done;
    logic [15:0]  data_pins_in;
    logic [1:0]   user_data_in;
    logic [31:0]  header_seen;
    int           d1_slips, fails, n_checks;
    scheme_t      scheme;
    pin_drive_t   user_drive, pins;
    cfg_word_t    word_data;
    cfg_word_t    got [$];
    logic [7:0]   pat [8] = '{8'hA5, 8'h3C, 8'hF0, 8'h0F,
                             8'h81, 8'h7E, 8'h12, 8'hC4};

    cfg_pin_loader #(.CONFIG_BYTES(N_BYTES)) dut_u (
        .clk(clk), .rst(rst), .scheme(scheme), .ap_word_wide(ap_word_wide),
        .user_pin_ctl(user_pin_ctl), .user_drive(user_drive),
        .clock_pin_in(clock_pin_in), .data_pins_in(data_pins_in),
        .chip_enable_n(chip_enable_n), .pins(pins),
        .config_complete_flag_o(flag_o), .config_complete_flag_oe(flag_oe),
        .user_data_in(user_data_in), .word_valid(word_valid),
        .word_ready(word_ready), .word_data(word_data),
        .overflow(overflow), .config_done(config_done));

    cfg_partner_model partner_u (
        .clk(clk), .rst(rst), .scheme(scheme), .ap_word_wide(ap_word_wide),
        .pins(pins), .clock_pin_in(clock_pin_in),
        .data_pins_in(data_pins_in), .header_seen(header_seen),
        .d1_slips(d1_slips));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // collect every word the stream hands over
    always @(posedge clk)
        if (!rst && word_valid === 1'b1 && word_ready)
            got.push_back(word_data);

    // passive schemes never drive the clock; serial leaves bit 1 alone while loading
    always @(posedge clk)
        if (!rst && !scheme[1]) begin
            check("clock oe", pins.clk_oe, 0);
            if (scheme == SCHEME_PASSIVE_SERIAL && !config_done)
                check("bit1 oe", pins.d1_oe, 0);
        end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic start(input scheme_t s, input logic wide);
        rst <= 1'b1;
        scheme <= s;
        ap_word_wide <= wide;
        chip_enable_n <= 1'b1;
        user_pin_ctl <= 1'b0;
        word_ready <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        got.delete();
        @(posedge clk);
        check("flag at start", {flag_o, flag_oe}, 2'h1);
        chip_enable_n <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : start

    task automatic wait_done();
        for (int i = 0; i < 4000 && config_done !== 1'b1; i++) @(posedge clk);
        check("done", config_done, 1);
        check("flag oe after", flag_oe, 0);
        repeat (4) @(posedge clk);
    endtask : wait_done

    task automatic expect_words(input int n, input logic wide);
        check("word count", got.size(), n);
        for (int i = 0; i < n && i < got.size(); i++)
            check("word", got[i], wide ? {pat[2 * i + 1], pat[2 * i], 1'b1}
                                       : {8'h00, pat[i], 1'b0});
    endtask : expect_words

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_passive(input scheme_t s);
        start(s, 1'b0);
        for (int i = 0; i < N_BYTES; i++) begin
            if (i == N_BYTES - 1) check("early done", config_done, 0);
            partner_u.host_send(pat[i]);
        end
        wait_done();
        expect_words(N_BYTES, 1'b0);
        user_pin_ctl <= 1'b1;
        user_drive <= 6'h3D;
        repeat (3) @(posedge clk);
        check("bit0 user", {pins.d0_o, pins.d0_oe}, 2'h3);
        if (s == SCHEME_FAST_PASSIVE_PARALLEL)
            check("bit1 user", {pins.d1_o, pins.d1_oe}, 2'h1);
        got.delete();
        partner_u.host_send(pat[5]);
        check("late words", got.size(), 0);
        check("still done", {config_done, overflow}, 2'h2);
    endtask : t_passive

    task automatic t_overflow();
        start(SCHEME_FAST_PASSIVE_PARALLEL, 1'b0);
        word_ready <= 1'b0;
        partner_u.host_send(pat[0]);
        partner_u.host_send(pat[1]);
        check("full no loss", {overflow, word_valid}, 2'h1);
        partner_u.host_send(pat[2]);
        check("overflow", overflow, 1);
        word_ready <= 1'b1;
        repeat (4) @(posedge clk);
        expect_words(2, 1'b0);
    endtask : t_overflow

    task automatic t_active_serial();
        start(SCHEME_ACTIVE_SERIAL, 1'b0);
        word_ready <= 1'b0;
        repeat (700) @(posedge clk);
        check("clock driven", pins.clk_oe, 1);
        check("stalled", {config_done, word_valid}, 2'h1);
        word_ready <= 1'b1;
        wait_done();
        expect_words(N_BYTES, 1'b0);
        check("header", header_seen, READ_HEADER);
        check("cmd edge", d1_slips, 0);
        repeat (20) @(posedge clk);
        check("clock idle", {pins.clk_oe, pins.clk_o}, 2'h2);
        check("bit0 input", pins.d0_oe, 0);
        check("bit1 output", pins.d1_oe, 1);
    endtask : t_active_serial

    task automatic t_active_parallel(input logic wide);
        start(SCHEME_ACTIVE_PARALLEL, wide);
        wait_done();
        expect_words(wide ? N_BYTES / BYTES_PER_WIDE : N_BYTES, wide);
        user_pin_ctl <= 1'b1;
        user_drive <= 6'h37;
        repeat (3) @(posedge clk);
        check("bit0 bidir", {pins.d0_o, pins.d0_oe}, 2'h1);
        check("bit1 bidir", {pins.d1_o, pins.d1_oe}, 2'h3);
        check("user data in", user_data_in,
              wide ? pat[2][1:0] : pat[3][1:0]);
    endtask : t_active_parallel

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    initial begin
        fails = 0;
        n_checks = 0;
        rst = 1'b1;
        scheme = SCHEME_PASSIVE_SERIAL;
        ap_word_wide = 1'b0;
        user_pin_ctl = 1'b0;
        user_drive = 6'h00;
        chip_enable_n = 1'b1;
        word_ready = 1'b1;
        for (int i = 0; i < 8; i++) partner_u.mem[i] = pat[i];
        t_passive(SCHEME_PASSIVE_SERIAL);
        t_passive(SCHEME_FAST_PASSIVE_PARALLEL);
        t_overflow();
        t_active_serial();
        t_active_parallel(1'b0);
        t_active_parallel(1'b1);
        summarize();
    end

    // cut a hang short well past the expected run length
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        summarize();
    end
endmodule : cfg_pin_loader_tb_top
